// file: pkg/sfr_pkg.sv
// Constants and types for the serial flash continuous read front end
package sfr_pkg;

   localparam logic [7:0] OPC_LEGACY_READ = 8'he8;
   localparam logic [7:0] OPC_FAST_READ = 8'h1b;

   localparam logic [2:0] ADDR_BYTES = 3'h3;
   localparam logic [2:0] DUMMY_LEGACY = 3'h4;
   localparam logic [2:0] DUMMY_FAST = 3'h2;
   localparam logic [2:0] LAST_BIT = 3'h7;

   localparam int PAGE_W = 12;
   localparam int BYTE_W = 10;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;

   localparam logic [BYTE_W-1:0] PAGE_LAST_STD = 10'h20f;
   localparam logic [BYTE_W-1:0] PAGE_LAST_BIN = 10'h1ff;
   localparam logic [PAGE_W-1:0] PAGE_LAST = 12'hfff;

   localparam int CLK_PERIOD_NS = 10;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_OPC = 6'b000010,
      ST_ADDR = 6'b000100,
      ST_DUMMY = 6'b001000,
      ST_DATA = 6'b010000,
      ST_IGNORE = 6'b100000
   } sfr_state_t;

   localparam sfr_state_t STATE_RESET = ST_IDLE;

endpackage : sfr_pkg

// file: hdl/sfr_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides and flush
`timescale 1ns/1ps
module sfr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } sfr_fifo_regs_t;

   sfr_fifo_regs_t r;
   sfr_fifo_regs_t n;
   logic full;
   logic empty;

   // Extra pointer bit tells full from empty when the indexes meet
   assign empty = (r.wp == r.rp);
   assign full = (r.wp[AW-1:0] == r.rp[AW-1:0]) && (r.wp[AW] != r.rp[AW]);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = r.mem[r.rp[AW-1:0]];

   always_comb begin
      n = r;
      if (flush) begin
         n.wp = '0;
         n.rp = '0;
      end else begin
         if (in_valid && !full) begin
            n.mem[r.wp[AW-1:0]] = in_data;
            n.wp = r.wp + 1'b1;
         end
         if (out_ready && !empty) begin
            n.rp = r.rp + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   overflow_guard_a: assert property (@(posedge clk) disable iff (rst)
      full && !flush && !(out_ready && !empty) |=> full)
      else $error("fifo lost an entry while full");

endmodule : sfr_fifo

// file: hdl/sfr_cont_read.sv
// Continuous array read front end: serial command decode and data stream
`timescale 1ns/1ps
module sfr_cont_read (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic reset_n,
   input wire logic page_bin,
   output logic so,
   output logic so_oe,
   output logic mem_rd_req,
   output logic [sfr_pkg::PAGE_W-1:0] mem_page,
   output logic [sfr_pkg::BYTE_W-1:0] mem_byte,
   input wire logic mem_rd_valid,
   input wire logic [sfr_pkg::DATA_W-1:0] mem_rd_data
);
   import sfr_pkg::*;

   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic sck_s1;
      logic sck_s2;
      logic sck_s3;
      logic si_s1;
      logic si_s2;
      logic rn_s1;
      logic rn_s2;
      sfr_state_t state;
      logic [2:0] bit_cnt;
      logic [2:0] byte_cnt;
      logic [2:0] dummy_bytes;
      logic [ADDR_W-1:0] addr;
      logic [PAGE_W-1:0] page;
      logic [BYTE_W-1:0] byte_idx;
      logic [DATA_W-1:0] out_sh;
      logic [2:0] out_bit;
      logic pend;
      logic drop;
      logic so;
      logic so_oe;
      logic mem_req;
      logic [PAGE_W-1:0] mem_page;
      logic [BYTE_W-1:0] mem_byte;
   } sfr_regs_t;

   sfr_regs_t r;
   sfr_regs_t n;

   logic rise;
   logic fall;
   logic abort;
   logic fifo_push;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;
   logic fifo_flush;
   logic [DATA_W-1:0] fifo_data;
   logic [7:0] opc_full;
   logic [ADDR_W-1:0] addr_full;

   // Splits the three address bytes into page and byte for the page size
   function automatic logic [PAGE_W+BYTE_W-1:0] decode_addr(
      input logic [ADDR_W-1:0] a,
      input logic bin
   );
      if (bin) begin
         decode_addr = {a[20:9], 1'b0, a[8:0]};
      end else begin
         decode_addr = {a[21:10], a[9:0]};
      end
   endfunction : decode_addr

   // Buffer byte offset for the page size; continuous reads never use it
   function automatic logic [BYTE_W-1:0] buf_byte_of(
      input logic [ADDR_W-1:0] a,
      input logic bin
   );
      if (bin) begin
         buf_byte_of = {1'b0, a[8:0]};
      end else begin
         buf_byte_of = a[9:0];
      end
   endfunction : buf_byte_of

   function automatic logic [BYTE_W-1:0] page_last(input logic bin);
      page_last = bin ? PAGE_LAST_BIN : PAGE_LAST_STD;
   endfunction : page_last

   assign rise = r.sck_s2 & ~r.sck_s3;
   assign fall = ~r.sck_s2 & r.sck_s3;
   // Deselect or the reset pin both drop whatever is in flight
   assign abort = r.cs_s2 | ~r.rn_s2;
   assign opc_full = {r.addr[6:0], r.si_s2};
   assign addr_full = {r.addr[ADDR_W-2:0], r.si_s2};
   // Late data of an aborted fetch is thrown away, not queued
   assign fifo_push = mem_rd_valid & r.pend & ~r.drop & ~abort;

   always_comb begin
      n = r;
      fifo_pop = 1'b0;
      fifo_flush = 1'b0;
      n.cs_s1 = cs_n;
      n.cs_s2 = r.cs_s1;
      n.sck_s1 = sck;
      n.sck_s2 = r.sck_s1;
      n.sck_s3 = r.sck_s2;
      n.si_s1 = si;
      n.si_s2 = r.si_s1;
      n.rn_s1 = reset_n;
      n.rn_s2 = r.rn_s1;
      n.mem_req = 1'b0;
      if (mem_rd_valid && r.pend) begin
         n.pend = 1'b0;
         n.drop = 1'b0;
      end
      if (abort) begin
         n.state = ST_IDLE;
         n.so_oe = 1'b0;
         n.so = 1'b0;
         n.drop = n.pend;
         fifo_flush = 1'b1;
      end else begin
         case (r.state)
            ST_IDLE: begin
               n.state = ST_OPC;
               n.bit_cnt = '0;
               n.byte_cnt = '0;
               n.addr = '0;
            end
            // A falling edge before the first rise (mode 3) is harmless here
            ST_OPC: begin
               if (rise) begin
                  n.addr = {r.addr[ADDR_W-2:0], r.si_s2};
                  n.bit_cnt = r.bit_cnt + 3'h1;
                  if (r.bit_cnt == LAST_BIT) begin
                     n.addr = '0;
                     if (opc_full == OPC_LEGACY_READ) begin
                        n.state = ST_ADDR;
                        n.dummy_bytes = DUMMY_LEGACY;
                     end else if (opc_full == OPC_FAST_READ) begin
                        n.state = ST_ADDR;
                        n.dummy_bytes = DUMMY_FAST;
                     end else begin
                        n.state = ST_IGNORE;
                     end
                  end
               end
            end
            ST_ADDR: begin
               if (rise) begin
                  n.addr = addr_full;
                  n.bit_cnt = r.bit_cnt + 3'h1;
                  if (r.bit_cnt == LAST_BIT) begin
                     n.byte_cnt = r.byte_cnt + 3'h1;
                     if (r.byte_cnt == ADDR_BYTES - 3'h1) begin
                        // Leading dummy bits fall away in the decode
                        {n.page, n.byte_idx} =
                           decode_addr(addr_full, page_bin);
                        n.byte_cnt = '0;
                        n.state = ST_DUMMY;
                     end
                  end
               end
            end
            ST_DUMMY: begin
               if (rise) begin
                  n.bit_cnt = r.bit_cnt + 3'h1;
                  if (r.bit_cnt == LAST_BIT) begin
                     n.byte_cnt = r.byte_cnt + 3'h1;
                     if (r.byte_cnt == r.dummy_bytes - 3'h1) begin
                        n.state = ST_DATA;
                        n.out_bit = '0;
                     end
                  end
               end
            end
            ST_DATA: begin
               // Input is not looked at; only falling edges matter now
               if (fall) begin
                  n.so_oe = 1'b1;
                  n.out_bit = r.out_bit + 3'h1;
                  if (r.out_bit == 3'h0) begin
                     // An empty FIFO here means the array is too slow
                     n.so = fifo_data[DATA_W-1];
                     n.out_sh = {fifo_data[DATA_W-2:0], 1'b0};
                     fifo_pop = fifo_out_valid;
                  end else begin
                     n.so = r.out_sh[DATA_W-1];
                     n.out_sh = {r.out_sh[DATA_W-2:0], 1'b0};
                  end
               end
            end
            ST_IGNORE: begin
               n.so_oe = 1'b0;
            end
            default: begin
               n.state = ST_IDLE;
            end
         endcase
         // Prefetch from the array while the dummy bytes go by
         if ((r.state == ST_DUMMY || r.state == ST_DATA) && !r.pend &&
             fifo_in_ready) begin
            n.mem_req = 1'b1;
            n.mem_page = r.page;
            n.mem_byte = r.byte_idx;
            n.pend = 1'b1;
            if (r.byte_idx == page_last(page_bin)) begin
               n.byte_idx = '0;
               n.page = r.page + 12'h001;
            end else begin
               n.byte_idx = r.byte_idx + 10'h001;
            end
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
         r.cs_s1 <= 1'b1;
         r.cs_s2 <= 1'b1;
         r.state <= STATE_RESET;
      end else begin
         r <= n;
      end
   end

   sfr_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .flush(fifo_flush),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(mem_rd_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   assign so = r.so;
   assign so_oe = r.so_oe;
   assign mem_rd_req = r.mem_req;
   assign mem_page = r.mem_page;
   assign mem_byte = r.mem_byte;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   deselect_float_a: assert property (r.cs_s2 |=> !so_oe)
      else $error("output still driven after deselect");

   idle_float_a: assert property (r.state == ST_IDLE |-> !so_oe)
      else $error("output driven while idle");

   drive_in_data_a: assert property (so_oe |-> r.state == ST_DATA)
      else $error("output driven outside the data phase");

   ignore_float_a: assert property (
      r.state == ST_IGNORE |-> !so_oe ##1 !so_oe)
      else $error("unknown opcode drove the output");

   opcode_len_a: assert property (
      r.state == ST_OPC && rise && !abort && r.bit_cnt == LAST_BIT
      |=> r.state inside {ST_ADDR, ST_IGNORE})
      else $error("opcode not taken after eight bits");

   msb_first_a: assert property (
      r.state == ST_DATA && fall && !abort && r.out_bit == 3'h0
      && fifo_out_valid |=> so == $past(fifo_data[DATA_W-1]))
      else $error("data byte not sent msb first");

   dummy_count_a: assert property (
      $rose(r.state == ST_DUMMY) |->
      (r.state != ST_DATA) [*8])
      else $error("data phase came before the dummy bytes");

   std_decode_a: assert property (
      r.state == ST_ADDR && rise && !abort && !page_bin &&
      r.bit_cnt == LAST_BIT && r.byte_cnt == 3'h2 |=>
      r.page == $past(addr_full[21:10]) &&
      r.byte_idx == buf_byte_of($past(addr_full), 1'b0))
      else $error("standard address decode wrong");

   bin_decode_a: assert property (
      r.state == ST_ADDR && rise && !abort && page_bin &&
      r.bit_cnt == LAST_BIT && r.byte_cnt == 3'h2 |=>
      r.page == $past(addr_full[20:9]) &&
      r.byte_idx == buf_byte_of($past(addr_full), 1'b1))
      else $error("binary address decode wrong");

   page_cross_a: assert property (
      n.mem_req && !abort && r.byte_idx == page_last(page_bin) |=>
      r.byte_idx == '0 && r.page == $past(r.page) + 12'h001)
      else $error("page crossover wrong");

   array_wrap_a: assert property (
      n.mem_req && !abort && r.page == PAGE_LAST &&
      r.byte_idx == page_last(page_bin) |=> r.page == '0)
      else $error("array end did not wrap to page zero");

   hw_reset_a: assert property (!r.rn_s2 |=> r.state == ST_IDLE)
      else $error("reset pin did not return to idle");

   fetch_stall_a: assert property (n.mem_req |-> fifo_in_ready)
      else $error("fetch issued with a full FIFO");

   // Between falls the output holds, so the host sees a whole bit time
   so_hold_a: assert property (
      r.state == ST_DATA && !fall && !abort |=> $stable(so))
      else $error("output moved without a serial clock fall");

   // Command bits advance only on a synchronised rise
   bit_hold_a: assert property (
      r.state inside {ST_OPC, ST_ADDR, ST_DUMMY} && !rise && !abort
      |=> $stable(r.bit_cnt))
      else $error("bit counter moved without a serial clock rise");

   // Stale prefetched bytes must never reach the next frame
   flush_abort_a: assert property (abort |=> !fifo_out_valid)
      else $error("prefetch queue not emptied on deselect");

   // One fetch in flight keeps the queue from overrunning
   one_fetch_a: assert property (mem_rd_req |=> !mem_rd_req)
      else $error("second fetch issued while one is outstanding");

   stream_step_a: assert property (
      n.mem_req && !abort && r.byte_idx != page_last(page_bin) |=>
      r.byte_idx == $past(r.byte_idx) + 10'h001 && $stable(r.page))
      else $error("address counter did not step by one byte");

   legacy_stream_c: cover property (
      r.state == ST_DATA && r.dummy_bytes == DUMMY_LEGACY && so_oe);
   fast_stream_c: cover property (
      r.state == ST_DATA && r.dummy_bytes == DUMMY_FAST && so_oe);
   page_cross_c: cover property (
      n.mem_req && r.byte_idx == page_last(page_bin));
   abort_in_data_c: cover property (r.state == ST_DATA && r.cs_s2);
   array_wrap_c: cover property (n.mem_req && r.page == PAGE_LAST &&
      r.byte_idx == page_last(page_bin));

endmodule : sfr_cont_read

// file: verification/sfr_host_model.sv
// Host side serial master model that drives the read front end's link
`timescale 1ns/1ps
module sfr_host_model (
   output logic cs_n,
   output logic sck,
   output logic si,
   input wire logic so,
   input wire logic so_oe
);
   localparam realtime HALF = 62.5;
   logic [7:0] rx[$];
   logic oe_pre;
   logic oe_dat;
   logic oe_any;
   logic oe_end;

   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b1;
   end

   // Output is sampled at the rise, a full half period after the fall
   task automatic slot(input logic b, output logic q, output logic oe);
      sck <= 1'b0;
      si <= b;
      #HALF;
      // The pin has no pull, so a floated output reads as the wrong bit
      q = so_oe ? so : ~so;
      oe = so_oe;
      sck <= 1'b1;
      #HALF;
   endtask : slot

   // Newer fast read is the one hosts should normally issue
   task automatic frame(input logic [7:0] opc, input logic [23:0] a,
      input int nd, input int nb, input logic m3);
      logic [63:0] hdr;
      logic q;
      logic oe;
      logic [7:0] byt;
      hdr = {opc, a, 32'ha5a5a5a5};
      rx.delete();
      oe_pre = 1'b0;
      oe_dat = 1'b1;
      oe_any = 1'b0;
      sck <= m3;
      #HALF;
      cs_n <= 1'b0;
      #HALF;
      for (int i = 0; i < 32 + 8 * nd; i++) begin
         slot(hdr[63-i], q, oe);
         oe_pre = oe_pre | oe;
      end
      for (int k = 0; k < nb; k++) begin
         for (int j = 7; j >= 0; j--) begin
            slot(j[0], q, oe);
            byt[j] = q;
            oe_dat = oe_dat & oe;
            oe_any = oe_any | oe;
         end
         rx.push_back(byt);
      end
      if (!m3) begin
         sck <= 1'b0;
      end
      #HALF;
      cs_n <= 1'b1;
      si <= ~si;
      #60;
      oe_end = so_oe;
      #100;
   endtask : frame
endmodule : sfr_host_model

// file: verification/tb_serial_flash_continuous_read.sv
// Testbench: host frames against the read front end with an array model
`timescale 1ns/1ps
module tb_serial_flash_continuous_read;
   import sfr_pkg::*;
   logic clk, rst, reset_n, page_bin, cs_n, sck, si, so, so_oe;
   logic mem_rd_req, mem_rd_valid;
   logic [PAGE_W-1:0] mem_page;
   logic [BYTE_W-1:0] mem_byte;
   logic [DATA_W-1:0] mem_rd_data;
   int n_mismatch = 0;
   int samples_checked = 0;
   integer seed = 32'h8aa1;

   initial clk = 1'b0;
   always #5 clk = ~clk;

   sfr_cont_read DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck),
      .si(si), .reset_n(reset_n), .page_bin(page_bin), .so(so),
      .so_oe(so_oe), .mem_rd_req(mem_rd_req), .mem_page(mem_page),
      .mem_byte(mem_byte), .mem_rd_valid(mem_rd_valid),
      .mem_rd_data(mem_rd_data));
   sfr_host_model u_host (.cs_n(cs_n), .sck(sck), .si(si), .so(so),
      .so_oe(so_oe));

   function automatic logic [7:0] mem_f(input int pg, input int by);
      return 8'((pg * 7) ^ (by * 13) ^ (pg >> 3));
   endfunction : mem_f

   // Random latency stalls the prefetch so the FIFO fills, but it never runs dry
   initial begin : array_model
      int pg, by, lat;
      mem_rd_valid = 1'b0;
      mem_rd_data = 8'h00;
      forever begin
         @(posedge clk);
         if (mem_rd_req === 1'b1) begin
            pg = int'(mem_page);
            by = int'(mem_byte);
            lat = 1 + {$random(seed)} % 24;
            repeat (lat) @(posedge clk);
            mem_rd_valid <= 1'b1;
            mem_rd_data <= mem_f(pg, by);
            @(posedge clk);
            mem_rd_valid <= 1'b0;
         end
      end
   end

   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   task automatic rd(input logic [7:0] opc, input logic bin, input int pg,
      input int by, input int nb, input logic m3);
      logic [23:0] a;
      int last;
      @(posedge clk);
      page_bin <= bin;
      a = bin ? 24'(pg * 512 + by) : 24'(pg * 1024 + by);
      a[23] = 1'b1;
      last = bin ? 511 : 527;
      u_host.frame(opc, a, (opc == OPC_LEGACY_READ) ? 4 : 2, nb, m3);
      chk("oe_pre", u_host.oe_pre, 0);
      chk("oe_end", u_host.oe_end, 0);
      chk("oe_dat", u_host.oe_dat, 1);
      for (int i = 0; i < nb; i++) begin
         chk("data", u_host.rx[i], mem_f(pg, by));
         if (by == last) begin
            by = 0;
            pg = (pg + 1) % 4096;
         end else begin
            by++;
         end
      end
   endtask : rd

   initial begin : main
      logic b;
      rst = 1'b1;
      reset_n = 1'b1;
      page_bin = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rd(OPC_FAST_READ, 0, 12, 5, 20, 0);
      rd(OPC_LEGACY_READ, 0, 5, 526, 4, 1);
      rd(OPC_FAST_READ, 0, 4095, 525, 5, 1);
      rd(OPC_LEGACY_READ, 1, 4095, 510, 4, 0);
      rd(OPC_FAST_READ, 1, 77, 509, 5, 1);
      for (int i = 0; i < 4; i++) begin
         b = 1'($random(seed));
         rd($random(seed) & 1 ? OPC_FAST_READ : OPC_LEGACY_READ, b,
            {$random(seed)} % 4096, {$random(seed)} % (b ? 512 : 528), 3,
            1'($random(seed)));
      end
      u_host.frame(8'h03, 24'h012345, 2, 2, 0);
      chk("oe_unknown", u_host.oe_any, 0);
      @(posedge clk);
      reset_n <= 1'b0;
      #50;
      u_host.frame(OPC_FAST_READ, 24'h000100, 2, 2, 1);
      chk("oe_reset", u_host.oe_any, 0);
      @(posedge clk);
      reset_n <= 1'b1;
      #50;
      rd(OPC_FAST_READ, 0, 300, 100, 3, 0);
      summarize();
   end

   initial begin : watchdog
      #900000;
      n_mismatch++;
      summarize();
   end
endmodule : tb_serial_flash_continuous_read
